// [buck_mode_pkg.sv]
// Package with frame layout, register offsets, field positions and reset values for the buck mode control bank.
package buck_mode_pkg;
  // Register addresses inside the device register space.
  localparam logic [5:0] ADDR_UNLOCK_CTRL = 6'h01;
  localparam logic [5:0] ADDR_CURRENT_MODE = 6'h02;
  localparam logic [5:0] ADDR_PHASE_WINDOW = 6'h03;
  // Control register one unlock bit position.
  localparam int UNLOCK_BIT = 1;
  // Field positions of the current and mode register.
  localparam int PEAK_A_LSB = 18;
  localparam int PEAK_B_LSB = 12;
  localparam int TOFF_A_LSB = 8;
  localparam int TOFF_B_LSB = 4;
  localparam int STANDBY_BIT = 3;
  localparam int ACTIVE_BIT = 2;
  localparam int RESV_BIT = 1;
  localparam int PARITY_BIT = 0;
  // Reset values; trimmed fields arrive on ports and are caught after reset.
  localparam logic [5:0] PEAK_B_RESET = 6'h20;
  localparam logic [3:0] TOFF_B_RESET = 4'hF;
  // Phase and window register fields reset as whole word, parity bit zero.
  localparam logic [23:0] PHASE_WINDOW_RESET = 24'h00CD82;
  // Payload of one valid SPI frame handed to the bank.
  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] addr;
    logic [23:0] data;
  } spi_frame_t;
  // Operating mode of the device, one-hot.
  typedef enum logic [2:0] {
    MODE_LIMP = 3'h1,
    MODE_ACTIVE = 3'h2,
    MODE_STANDBY = 3'h4
  } op_mode_t;
endpackage

// [frame_parity_check.sv]
// Odd parity checker for one 24-bit control frame.
module frame_parity_check
  import buck_mode_pkg::*;
(
  input wire logic [23:0] data_i,
  output logic ok_o
);
  // Odd parity: the whole word, parity bit included, must have an odd count of ones.
  always_comb begin
    ok_o = ^data_i; // R16
  end
endmodule

// [led_buck_mode_control_regs.sv]
// Control registers two and three of the dual buck driver with unlock-guarded mode bits.
// Function
// R1 - Channel A peak current, bits 23-18, trimmed
// R2 - Channel B peak current, bits 17-12, resets 100000
// R3 - Channel A volt-offtime, bits 11-8, trimmed
// R4 - Channel B volt-offtime, bits 7-4, resets 1111
// R5 - Bit 3 standby request, standby when active 0
// R6 - Standby request set only while unlocked
// R7 - Standby request clears without unlock
// R8 - Master sends unlock then standby frame
// R9 - Bit 2 active enable, limp-home when both 0
// R10 - Wake-up always enters limp-home state
// R11 - Active mode when enable 1, standby 0
// R12 - Active enable set only while unlocked
// R13 - Active enable clears without unlock
// R14 - Master sends unlock then active frame
// R15 - Master writes reserved bit 1 as one
// R16 - Bit 0 carries odd frame parity
// R17 - Register three read/write at address 3
// R18 - Unlock clears after next valid frame
module led_buck_mode_control_regs
  import buck_mode_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire spi_frame_t frame_i,
  input wire logic [5:0] trim_peak_a_i,
  input wire logic [3:0] trim_toff_a_i,
  input wire logic wake_up_i,
  output logic [23:0] read_data_o,
  output logic parity_error_o,
  output logic unlock_o,
  output logic [5:0] chan_a_peak_current_sel_o,
  output logic [5:0] chan_b_peak_current_sel_o,
  output logic [3:0] chan_a_volt_offtime_sel_o,
  output logic [3:0] chan_b_volt_offtime_sel_o,
  output logic standby_request_o,
  output logic active_enable_o,
  output logic [3:0] chan_a_phase_sel_o,
  output logic [3:0] chan_b_phase_sel_o,
  output logic pwm_sync_o,
  output logic [1:0] chan_a_input_window_o,
  output logic [1:0] chan_b_input_window_o,
  output op_mode_t mode_o
);
  // All state of the bank in one packed word.
  typedef struct packed {
    logic trim_pending;
    logic unlock;
    logic parity_error;
    logic [23:0] current_mode;
    logic [23:0] phase_window;
    logic [23:0] read_data;
    op_mode_t mode;
  } bank_state_t;

  // Registered state and the value it takes at the next edge.
  bank_state_t state_r;
  bank_state_t state_nxt;
  logic parity_ok; // High when the incoming frame has odd parity.
  logic frame_ok; // A frame that is valid and passes parity.
  logic std_next; // Standby bit as it will be after this cycle when no wake-up forces it low.
  logic act_next; // Active bit as it will be after this cycle when no wake-up forces it low.

  // Parity of the incoming frame is checked in the leaf module.
  frame_parity_check parity_u (
    .data_i(frame_i.data),
    .ok_o(parity_ok)
  );

  // A frame that fails parity only raises the error flag; it leaves the registers and a pending unlock untouched.
  assign frame_ok = frame_i.valid && parity_ok; // R16

  // Derive the operating mode from the two mode bits.
  function automatic op_mode_t mode_of(input logic stby, input logic act);
    if (stby && !act) begin
      mode_of = MODE_STANDBY; // R5
    end else if (!stby && act) begin
      mode_of = MODE_ACTIVE; // R11
    end else if (!stby && !act) begin
      mode_of = MODE_LIMP; // R9
    end else begin
      // Both bits set is not a documented mode; the safe choice is limp-home.
      mode_of = MODE_LIMP;
    end
  endfunction

  // Set only under unlock, clear always: the guarded-bit write policy.
  function automatic logic guarded_bit(input logic old_v, input logic wr_v, input logic unl);
    if (!wr_v) begin
      guarded_bit = 1'b0; // R7 R13
    end else if (unl) begin
      guarded_bit = 1'b1; // R6 R12
    end else begin
      guarded_bit = old_v;
    end
  endfunction

  // Next-state logic for the whole bank.
  always_comb begin
    state_nxt = state_r;
    std_next = state_r.current_mode[STANDBY_BIT];
    act_next = state_r.current_mode[ACTIVE_BIT];
    // Trimmed fields are caught on the first clock after reset release, never under reset itself.
    if (state_r.trim_pending) begin
      state_nxt.trim_pending = 1'b0;
      state_nxt.current_mode[PEAK_A_LSB +: 6] = trim_peak_a_i; // R1
      state_nxt.current_mode[TOFF_A_LSB +: 4] = trim_toff_a_i; // R3
    end
    if (frame_i.valid) begin
      // A bad frame is flagged and changes no register.
      state_nxt.parity_error = !parity_ok; // R16
    end
    if (frame_ok) begin
      // Any valid frame with good parity consumes a pending unlock; unlock frame itself may set it again.
      state_nxt.unlock = 1'b0; // R18
      if (frame_i.write) begin
        case (frame_i.addr)
          ADDR_UNLOCK_CTRL: begin
            // Only the unlock bit of register one matters here; its other fields live outside this bank.
            state_nxt.unlock = frame_i.data[UNLOCK_BIT];
          end
          ADDR_CURRENT_MODE: begin
            // Mode bits pass through the guarded policy; a locked set keeps the old value.
            std_next = guarded_bit(state_r.current_mode[STANDBY_BIT], frame_i.data[STANDBY_BIT], state_r.unlock);
            act_next = guarded_bit(state_r.current_mode[ACTIVE_BIT], frame_i.data[ACTIVE_BIT], state_r.unlock);
            state_nxt.current_mode[23:4] = frame_i.data[23:4]; // R1 R2 R3 R4
            state_nxt.current_mode[STANDBY_BIT] = std_next; // R5
            state_nxt.current_mode[ACTIVE_BIT] = act_next; // R9
            // Reserved bit is stored as written; the master is expected to send one.
            state_nxt.current_mode[RESV_BIT] = frame_i.data[RESV_BIT]; // R15
            state_nxt.current_mode[PARITY_BIT] = 1'b0;
          end
          ADDR_PHASE_WINDOW: begin
            // Register three keeps every written bit but parity, sync bit 6 included until it clears itself, so a wrong reserved bit reads back as sent.
            state_nxt.phase_window = {frame_i.data[23:1], 1'b0}; // R17
          end
          default: begin
            // Other addresses belong to registers outside this bank.
          end
        endcase
      end else begin
        case (frame_i.addr)
          ADDR_CURRENT_MODE: begin
            // A read captures the word as it stood before this edge.
            state_nxt.read_data = state_r.current_mode;
          end
          ADDR_PHASE_WINDOW: begin
            state_nxt.read_data = state_r.phase_window; // R17
          end
          default: begin
            // Unmapped reads return zero so stale data never leaks out.
            state_nxt.read_data = 24'h000000;
          end
        endcase
      end
    end
    // Sync request is a one-shot: it clears itself after one clock cycle unless the same frame rewrites it.
    if (state_r.phase_window[6] && !(frame_ok && frame_i.write && frame_i.addr == ADDR_PHASE_WINDOW)) begin
      state_nxt.phase_window[6] = 1'b0;
    end
    // Mode is derived from the bits that will be stored, so it never lags them by a cycle.
    state_nxt.mode = mode_of(std_next, act_next);
    // A wake-up event forces limp-home and drops both mode bits, overriding any frame.
    if (wake_up_i) begin
      state_nxt.current_mode[STANDBY_BIT] = 1'b0; // R10
      state_nxt.current_mode[ACTIVE_BIT] = 1'b0; // R10
      state_nxt.mode = MODE_LIMP; // R10
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      // Trimmed fields read zero under reset; the pending flag loads them one edge later.
      state_r.trim_pending <= 1'b1;
      state_r.unlock <= 1'b0;
      state_r.parity_error <= 1'b0;
      state_r.current_mode <= {6'h00, PEAK_B_RESET, 4'h0, TOFF_B_RESET, 4'h0}; // R2 R4
      state_r.phase_window <= PHASE_WINDOW_RESET;
      state_r.read_data <= 24'h000000;
      state_r.mode <= MODE_LIMP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs are straight taps of the registered state.
  assign read_data_o = state_r.read_data;
  assign parity_error_o = state_r.parity_error;
  assign unlock_o = state_r.unlock;
  assign chan_a_peak_current_sel_o = state_r.current_mode[PEAK_A_LSB +: 6];
  assign chan_b_peak_current_sel_o = state_r.current_mode[PEAK_B_LSB +: 6];
  assign chan_a_volt_offtime_sel_o = state_r.current_mode[TOFF_A_LSB +: 4];
  assign chan_b_volt_offtime_sel_o = state_r.current_mode[TOFF_B_LSB +: 4];
  assign standby_request_o = state_r.current_mode[STANDBY_BIT];
  assign active_enable_o = state_r.current_mode[ACTIVE_BIT];
  assign chan_a_phase_sel_o = state_r.phase_window[23:20];
  assign chan_b_phase_sel_o = state_r.phase_window[19:16];
  // The sync request is visible for one cycle unless a register three write in that cycle sets it again; whoever uses it must not poll for it.
  assign pwm_sync_o = state_r.phase_window[6];
  assign chan_a_input_window_o = state_r.phase_window[5:4];
  assign chan_b_input_window_o = state_r.phase_window[3:2];
  assign mode_o = state_r.mode;

  // A locked write to standby never sets the bit; the check accepts it holding or clearing.
  a_standby_lock_hold: assert property (@(posedge clock_i) disable iff (srst_i) // R6
    (frame_ok && frame_i.write && frame_i.addr == ADDR_CURRENT_MODE && !state_r.unlock && !wake_up_i)
    |=> (standby_request_o == $past(standby_request_o)) || !standby_request_o)
    else $error("standby set without unlock");

  // A locked write of one to active enable leaves a clear bit clear.
  a_active_lock_hold: assert property (@(posedge clock_i) disable iff (srst_i) // R12
    (frame_ok && frame_i.write && frame_i.addr == ADDR_CURRENT_MODE && !state_r.unlock && !active_enable_o)
    |=> !active_enable_o)
    else $error("active enable set without unlock");

  // Writing zero clears standby regardless of unlock.
  a_standby_clear_free: assert property (@(posedge clock_i) disable iff (srst_i) // R7
    (frame_ok && frame_i.write && frame_i.addr == ADDR_CURRENT_MODE && !frame_i.data[STANDBY_BIT])
    |=> !standby_request_o)
    else $error("standby not cleared");

  // Writing zero clears active enable regardless of unlock.
  a_active_clear_free: assert property (@(posedge clock_i) disable iff (srst_i) // R13
    (frame_ok && frame_i.write && frame_i.addr == ADDR_CURRENT_MODE && !frame_i.data[ACTIVE_BIT])
    |=> !active_enable_o)
    else $error("active enable not cleared");

  // Unlock survives only until the next valid frame with good parity that does not relock.
  a_unlock_one_shot: assert property (@(posedge clock_i) disable iff (srst_i) // R18
    (state_r.unlock && frame_ok && !(frame_i.write && frame_i.addr == ADDR_UNLOCK_CTRL))
    |=> !unlock_o)
    else $error("unlock not consumed");

  // Unlocked write sequence reaches active mode in the next cycle.
  a_active_entry: assert property (@(posedge clock_i) disable iff (srst_i) // R11
    (state_r.unlock && frame_ok && frame_i.write && frame_i.addr == ADDR_CURRENT_MODE
     && frame_i.data[ACTIVE_BIT] && !frame_i.data[STANDBY_BIT] && !wake_up_i)
    |=> (mode_o == MODE_ACTIVE) && active_enable_o)
    else $error("active mode not entered");

  // Mode follows the two bits once stable.
  a_mode_standby: assert property (@(posedge clock_i) disable iff (srst_i) // R5
    (standby_request_o && !active_enable_o) |-> (mode_o == MODE_STANDBY))
    else $error("standby mode mismatch");

  // Both bits low means limp-home.
  a_mode_limp: assert property (@(posedge clock_i) disable iff (srst_i) // R9
    (!standby_request_o && !active_enable_o) |-> (mode_o == MODE_LIMP))
    else $error("limp mode mismatch");

  // Wake-up lands in limp-home on the next cycle.
  a_wake_limp: assert property (@(posedge clock_i) disable iff (srst_i) // R10
    wake_up_i |=> (mode_o == MODE_LIMP) && !active_enable_o && !standby_request_o)
    else $error("wake-up did not enter limp-home");

  // A frame with bad parity changes no field and raises the error flag.
  a_parity_reject: assert property (@(posedge clock_i) disable iff (srst_i) // R16
    (frame_i.valid && !parity_ok && !wake_up_i && !state_r.trim_pending && !pwm_sync_o)
    |=> parity_error_o && $stable(state_r.current_mode) && $stable(state_r.phase_window))
    else $error("bad parity frame accepted");

  // Register three stores written data on a good frame.
  a_reg3_write: assert property (@(posedge clock_i) disable iff (srst_i) // R17
    (frame_ok && frame_i.write && frame_i.addr == ADDR_PHASE_WINDOW)
    |=> chan_a_phase_sel_o == $past(frame_i.data[23:20]) && chan_b_input_window_o == $past(frame_i.data[3:2]))
    else $error("register three write lost");

  // A pending sync request lasts one cycle unless the same frame rewrites it.
  a_sync_one_shot: assert property (@(posedge clock_i) disable iff (srst_i) // R17
    (pwm_sync_o && !(frame_ok && frame_i.write && frame_i.addr == ADDR_PHASE_WINDOW))
    |=> !pwm_sync_o)
    else $error("sync request not cleared");

  // Unlocked standby write with enable low lands in standby.
  a_standby_entry: assert property (@(posedge clock_i) disable iff (srst_i) // R6
    (state_r.unlock && frame_ok && frame_i.write && frame_i.addr == ADDR_CURRENT_MODE
     && frame_i.data[STANDBY_BIT] && !frame_i.data[ACTIVE_BIT] && !wake_up_i)
    |=> (mode_o == MODE_STANDBY) && standby_request_o)
    else $error("standby mode not entered");

  // Channel B fields take the written word on any good register two write.
  a_chan_b_fields: assert property (@(posedge clock_i) disable iff (srst_i) // R2
    (frame_ok && frame_i.write && frame_i.addr == ADDR_CURRENT_MODE)
    |=> chan_b_peak_current_sel_o == $past(frame_i.data[17:12])
        && chan_b_volt_offtime_sel_o == $past(frame_i.data[7:4]))
    else $error("channel B fields not written");

  // Channel A fields take the written word; a frame wins over a pending trim load.
  a_chan_a_fields: assert property (@(posedge clock_i) disable iff (srst_i) // R1
    (frame_ok && frame_i.write && frame_i.addr == ADDR_CURRENT_MODE)
    |=> chan_a_peak_current_sel_o == $past(frame_i.data[23:18])
        && chan_a_volt_offtime_sel_o == $past(frame_i.data[11:8]))
    else $error("channel A fields not written");

  // An unlock frame with the unlock bit set arms the next frame.
  a_unlock_arm: assert property (@(posedge clock_i) disable iff (srst_i) // R18
    (frame_ok && frame_i.write && frame_i.addr == ADDR_UNLOCK_CTRL && frame_i.data[UNLOCK_BIT])
    |=> unlock_o)
    else $error("unlock not armed");

  // A read of register two returns the mode bits as they stood.
  a_read_mode_bits: assert property (@(posedge clock_i) disable iff (srst_i) // R5
    (frame_ok && !frame_i.write && frame_i.addr == ADDR_CURRENT_MODE)
    |=> read_data_o[STANDBY_BIT] == $past(standby_request_o) && read_data_o[ACTIVE_BIT] == $past(active_enable_o))
    else $error("mode bits read back wrong");
endmodule

// [spi_master_model.sv]
// Behavioural SPI master that hands decoded frames to the register bank.
module spi_master_model
  import buck_mode_pkg::*;
(
  input wire logic clock_i,
  output spi_frame_t frame_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero.
  initial frame_o = '0;
  // One frame: valid for one cycle, then the payload is scrambled so stale data never looks valid.
  task automatic send(input logic wr, input logic [5:0] a, input logic [23:0] d, input logic bad);
    logic [23:0] w;
    w = d;
    if (a == ADDR_CURRENT_MODE && wr) begin
      w[1] = 1'b1;
    end
    w[0] = ~(^w[23:1]) ^ bad;
    @(posedge clock_i);
    frame_o <= '{valid: 1'b1, write: wr, addr: a, data: w};
    @(posedge clock_i);
    frame_o <= '{valid: 1'b0, write: wr, addr: ~a, data: ~w};
  endtask
endmodule

// [test_led_buck_mode_control_regs.sv]
// Self-checking bench for the buck current and mode register bank.
`define CHECK(act, exp) begin tests_run++; if ((act) !== (exp)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp); end end
module test_led_buck_mode_control_regs;
  import buck_mode_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] TRIM_PA = 6'h2A; // Trim values are arbitrary but distinct from resets.
  localparam logic [3:0] TRIM_TA = 4'h5;
  logic clock_i, srst_i, wake_up_i, perr, unl, sb, en, psync;
  spi_frame_t frame;
  logic [23:0] rd;
  logic [5:0] pa, pb;
  logic [3:0] ta, tb, pha, phb;
  logic [1:0] wa, wb;
  op_mode_t mode;
  int miscompares = 0;
  int tests_run = 0;
  spi_master_model master (.clock_i(clock_i), .frame_o(frame));
  led_buck_mode_control_regs uut (.clock_i(clock_i), .srst_i(srst_i), .frame_i(frame),
    .trim_peak_a_i(TRIM_PA), .trim_toff_a_i(TRIM_TA), .wake_up_i(wake_up_i), .read_data_o(rd),
    .parity_error_o(perr), .unlock_o(unl), .chan_a_peak_current_sel_o(pa), .chan_b_peak_current_sel_o(pb),
    .chan_a_volt_offtime_sel_o(ta), .chan_b_volt_offtime_sel_o(tb), .standby_request_o(sb),
    .active_enable_o(en), .chan_a_phase_sel_o(pha), .chan_b_phase_sel_o(phb), .pwm_sync_o(psync),
    .chan_a_input_window_o(wa), .chan_b_input_window_o(wb), .mode_o(mode));
  // Sample away from the rising edge so register updates have landed.
  task automatic settle();
    @(negedge clock_i);
  endtask
  // Register two word with the reserved bit set as the master must.
  function automatic logic [23:0] w2(input logic [5:0] a, b, input logic [3:0] c, d, input logic s, e);
    return {a, b, c, d, s, e, 2'b10};
  endfunction
  task automatic unlock();
    master.send(1'b1, ADDR_UNLOCK_CTRL, 24'h000002, 1'b0);
  endtask
  task automatic wr2(input logic s, e);
    master.send(1'b1, ADDR_CURRENT_MODE, w2(6'h3F, 6'h01, 4'h0, 4'hA, s, e), 1'b0);
    settle();
  endtask
  // Read frame, then compare the returned word.
  task automatic rd_chk(input logic [5:0] a, input logic [23:0] e);
    master.send(1'b0, a, 24'h000000, 1'b0);
    settle();
    `CHECK(rd, e)
  endtask
  task automatic t_reset_vals();
    `CHECK(pa, TRIM_PA)
    `CHECK(pb, 6'h20)
    `CHECK(ta, TRIM_TA)
    `CHECK(tb, 4'hF)
    `CHECK(sb, 1'b0)
    `CHECK(en, 1'b0)
    `CHECK(mode, MODE_LIMP)
    rd_chk(ADDR_CURRENT_MODE, {TRIM_PA, 6'h20, TRIM_TA, 4'hF, 4'h0});
    `CHECK(psync, 1'b0)
    rd_chk(ADDR_PHASE_WINDOW, 24'h00CD82);
  endtask
  // Locked write: fields land at the written codes 3F, 01, 0 and A, mode bits stay clear.
  task automatic t_locked();
    wr2(1'b1, 1'b1);
    `CHECK(sb, 1'b0)
    `CHECK(en, 1'b0)
    rd_chk(ADDR_CURRENT_MODE, w2(6'h3F, 6'h01, 4'h0, 4'hA, 1'b0, 1'b0));
  endtask
  task automatic t_active();
    unlock();
    settle();
    `CHECK(unl, 1'b1)
    wr2(1'b0, 1'b1);
    `CHECK(unl, 1'b0)
    `CHECK(en, 1'b1)
    `CHECK(mode, MODE_ACTIVE)
    wr2(1'b0, 1'b0);
    `CHECK(en, 1'b0)
    `CHECK(mode, MODE_LIMP)
  endtask
  task automatic t_standby();
    unlock();
    wr2(1'b1, 1'b0);
    `CHECK(sb, 1'b1)
    `CHECK(mode, MODE_STANDBY)
    wr2(1'b0, 1'b0);
    `CHECK(sb, 1'b0)
    `CHECK(mode, MODE_LIMP)
  endtask
  // The unlock is spent on a register three frame, so the later enable is refused.
  task automatic t_once();
    unlock();
    master.send(1'b1, ADDR_PHASE_WINDOW, 24'hA5C3A6, 1'b0);
    settle();
    `CHECK({pha, phb, wa, wb}, 12'hA59)
    wr2(1'b0, 1'b1);
    `CHECK(en, 1'b0)
    rd_chk(ADDR_PHASE_WINDOW, 24'hA5C3A6);
  endtask
  // A sync request shows for one cycle, then reads back cleared.
  task automatic t_sync();
    master.send(1'b1, ADDR_PHASE_WINDOW, 24'h00CDC2, 1'b0);
    settle();
    `CHECK(psync, 1'b1)
    settle();
    `CHECK(psync, 1'b0)
    rd_chk(ADDR_PHASE_WINDOW, 24'h00CD82);
  endtask
  task automatic t_parity();
    master.send(1'b1, ADDR_CURRENT_MODE, w2(6'h00, 6'h00, 4'h0, 4'h0, 1'b0, 1'b0), 1'b1);
    settle();
    `CHECK(perr, 1'b1)
    `CHECK(pa, 6'h3F)
    rd_chk(ADDR_CURRENT_MODE, w2(6'h3F, 6'h01, 4'h0, 4'hA, 1'b0, 1'b0));
    `CHECK(perr, 1'b0)
  endtask
  task automatic t_wake();
    unlock();
    wr2(1'b0, 1'b1);
    `CHECK(en, 1'b1)
    @(posedge clock_i);
    wake_up_i <= 1'b1;
    @(posedge clock_i);
    wake_up_i <= 1'b0;
    settle();
    `CHECK(mode, MODE_LIMP)
    `CHECK(en, 1'b0)
  endtask
  task automatic end_of_test();
    $display("Counts: tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // 20 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // Hang guard: running out of cycles counts as a mismatch.
  initial begin
    repeat (2000) @(posedge clock_i);
    miscompares++;
    end_of_test();
  end
  initial begin
    srst_i = 1'b1;
    wake_up_i = 1'b0;
    repeat (10) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    settle();
    t_reset_vals();
    t_locked();
    t_active();
    t_standby();
    t_once();
    t_sync();
    t_parity();
    t_wake();
    end_of_test();
  end
endmodule
